// File: dv/sidp_host.sv
// Purpose: microprocessor model for the phase and control lines
// Assumes: tasks are called from one bench process
// Notes: lines change 2 ns after a rising edge
`timescale 1ns/1ps
module sidp_host (
    input wire logic clk,
    output logic [3:0] ph,
    output logic red,
    output logic lsel
);
    // lines idle high, open loop bit clear
    initial begin
        ph = 4'hF;
        red = 1'b0;
        lsel = 1'b0;
    end
    // present a drive pattern and control levels
    task automatic put(input logic [3:0] p, input logic r, input logic l);
        @(posedge clk);
        #2;
        ph = p;
        red = r;
        lsel = l;
    endtask
    // one serial bit: all lines low for n+1 cycles, then high again
    task automatic load(input logic r, input logic l, input int n);
        put(4'h0, r, l);
        repeat (n) @(posedge clk);
        put(4'hF, r, l);
        repeat (10) @(posedge clk);
    endtask
endmodule

// File: dv/sidp_props.sv
// Purpose: port assertions for the stepper input decode block
// Assumes: one clk domain, async active-high rst
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module sidp_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic loop_select_input,
    input wire logic current_trip,
    input wire logic low_side_drive_one,
    input wire logic low_side_drive_two,
    input wire logic low_side_drive_three,
    input wire logic low_side_drive_four,
    input wire logic high_side_chop_switch,
    input wire logic [9:0] current_ref_mv,
    input wire logic [5:0] drive_configuration_shift,
    input wire logic programming_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] lows;
    logic [5:0] cfg;
    logic [9:0] lvl;
    // grouped low sides and the reduced level the config asks for
    assign lows = {low_side_drive_four, low_side_drive_three,
                   low_side_drive_two, low_side_drive_one};
    assign cfg = drive_configuration_shift;
    assign lvl = cfg[1:0] == 2'h0 ? 10'h0C8 : cfg[1:0] == 2'h1 ? 10'h15E :
                 cfg[1:0] == 2'h2 ? 10'h0FA : 10'h1A9;
    sequence s_idle2; !programming_mode [*2]; endsequence
    sequence s_shift; $changed(cfg); endsequence
    property p_prog_off; programming_mode |-> lows == 4'h0 && !high_side_chop_switch; endproperty
    a_prog_off: assert property (p_prog_off) else $error("drive on in programming");
    property p_hold; s_idle2 |-> $stable(cfg); endproperty
    a_hold: assert property (p_hold) else $error("config moved outside programming");
    property p_once; s_shift |=> $stable(cfg) [*4]; endproperty
    a_once: assert property (p_once) else $error("second shift too soon");
    property p_shift; s_shift |-> cfg[5:1] == $past(cfg[4:0]); endproperty
    a_shift: assert property (p_shift) else $error("config did not shift up");
    property p_guard; s_shift |-> programming_mode && $past(programming_mode, 3); endproperty
    a_guard: assert property (p_guard) else $error("shift without guard time");
    property p_level;
        current_ref_mv != 10'h1F4 && $stable(cfg) |-> current_ref_mv == lvl;
    endproperty
    a_level: assert property (p_level) else $error("reduced level wrong");
    property p_ton_off;
        (cfg[3:2] == 2'h3 && loop_select_input) [*8] |-> !high_side_chop_switch;
    endproperty
    a_ton_off: assert property (p_ton_off) else $error("upper switch on when disabled");
    property p_trip;
        (current_trip && !loop_select_input) [*8]
            |-> !(high_side_chop_switch && $past(high_side_chop_switch));
    endproperty
    a_trip: assert property (p_trip) else $error("upper switch held through trip");
    property p_reset;
        disable iff (1'b0) rst |-> cfg == 6'h00 && lows == 4'h0 && !high_side_chop_switch;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs live in reset");
endmodule
bind sidp_stepper_input_decode sidp_props i_props (.*);

// File: dv/tb.sv
// Purpose: self-checking bench for the stepper input decode block
// Assumes: 20 MHz clk, reset held 20 cycles
// Notes: host model drives every phase and control line
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic clk = 1'b0;
    logic rst;
    logic trip = 1'b0;
    logic [3:0] ph, lows;
    logic red, lsel, hs, pm;
    logic [9:0] ref_mv;
    logic [5:0] cfg;
    int miscompares = 0;
    int comparisons = 0;
    // 50 ns clock
    always #25 clk = ~clk;
    sidp_host i_host (.clk(clk), .ph(ph), .red(red), .lsel(lsel));
    sidp_stepper_input_decode i_dut (.clk(clk), .rst(rst), .phase_line_one(ph[0]),
        .phase_line_two(ph[1]), .phase_line_three(ph[2]), .phase_line_four(ph[3]),
        .current_reduce_input(red), .loop_select_input(lsel), .current_trip(trip),
        .low_side_drive_one(lows[0]), .low_side_drive_two(lows[1]),
        .low_side_drive_three(lows[2]), .low_side_drive_four(lows[3]),
        .high_side_chop_switch(hs), .current_ref_mv(ref_mv),
        .drive_configuration_shift(cfg), .programming_mode(pm));
    // apply a pattern, let it settle, compare outputs
    task automatic chk(input logic [3:0] p, input logic r, input logic l, input logic [3:0] el,
                       input logic eh, input logic [9:0] er);
        i_host.put(p, r, l);
        repeat (12) @(posedge clk);
        #1;
        `CHK({pm, lows, hs}, {1'b0, el, eh})
        `CHK(ref_mv, er)
    endtask
    task automatic t_simpl;
        `CHK({cfg, lows, hs, ref_mv}, {11'h000, 10'h1F4})
        chk(4'b1101, 1'b0, 1'b0, 4'b1001, 1'b1, 10'h1F4);
        chk(4'b0111, 1'b0, 1'b0, 4'b0101, 1'b1, 10'h0C8);
        i_host.put(4'b1011, 1'b0, 1'b0);
        repeat (12) @(posedge clk);
        #1;
        `CHK(lows, 4'h0)
        $display("t_simpl done");
    endtask
    task automatic t_prog;
        logic [5:0] e;
        logic [5:0] bits;
        e = 6'h00;
        bits = 6'b101101;
        for (int k = 5; k >= 0; k--) begin
            i_host.load(bits[k] ^ k[0], k[0], k == 4 ? 40 : 12);
            e = {e[4:0], bits[k]};
            `CHK(cfg, e)
            if (k == 5) begin
                i_host.load(1'b1, 1'b0, 2);
                `CHK(cfg, e)
            end
        end
        $display("t_prog done");
    endtask
    task automatic t_full;
        chk(4'b0110, 1'b0, 1'b0, 4'b1001, 1'b1, 10'h1F4);
        chk(4'b1011, 1'b0, 1'b0, 4'b0100, 1'b1, 10'h15E);
        chk(4'b1010, 1'b1, 1'b0, 4'b0101, 1'b1, 10'h15E);
        chk(4'b1100, 1'b0, 1'b0, 4'b0000, 1'b0, 10'h15E);
        i_host.put(4'b0110, 1'b0, 1'b1);
        repeat (12) @(posedge clk);
        #1;
        `CHK(hs, 1'b0)
        $display("t_full done");
    endtask
    task automatic t_chop;
        chk(4'b0110, 1'b0, 1'b0, 4'b1001, 1'b1, 10'h1F4);
        #1 trip = 1'b1;
        repeat (10) @(posedge clk);
        `CHK({hs, lows}, 5'h0F)
        #1 trip = 1'b0;
        chk(4'b0101, 1'b0, 1'b0, 4'b1010, 1'b1, 10'h1F4);
        i_host.put(4'h0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        #1;
        `CHK({pm, lows, hs}, 6'h20)
        $display("t_chop done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #2;
        rst = 1'b0;
        t_simpl;
        t_prog;
        t_full;
        t_chop;
        print_verdict;
    end
    // watchdog at about five and a half times the expected run
    initial begin
        #100000;
        miscompares++;
        print_verdict;
    end
endmodule

// File: rtl/sidp_pkg.sv
// Purpose: types for the stepper input decode and programming block
// Assumes: nothing beyond the constants header
// Notes: programming clock generator states
package sidp_pkg;
    typedef enum logic [1:0] {
        SIDP_IDLE = 2'b00,
        SIDP_WAIT = 2'b01,
        SIDP_DONE = 2'b10
    } sidp_prog_e;
endpackage

// File: rtl/sidp_regs.svh
// Purpose: named constants for the stepper input decode and programming block
// Assumes: 20 MHz clk, 50 ns period
// Notes: bit positions of the configuration shift register and timing figures
`ifndef SIDP_REGS_SVH
`define SIDP_REGS_SVH
`define SIDP_CFG_W 6
`define SIDP_CFG_RESET 6'h00
`define SIDP_IN_RESET 7'h0F
`define SIDP_BIT_LVL0 0
`define SIDP_BIT_LVL1 1
`define SIDP_BIT_TON2 2
`define SIDP_BIT_TON3 3
`define SIDP_BIT_FREQ 4
`define SIDP_BIT_FULL 5
`define SIDP_CLK_HZ 20000000
`define SIDP_GUARD_NS 200
`define SIDP_GUARD_CYC ((`SIDP_GUARD_NS * (`SIDP_CLK_HZ / 1000000) + 999) / 1000)
`define SIDP_OSC_W 16
`define SIDP_OSC_PERIOD 16'h03E8
`define SIDP_TON_75 16'h02EE
`define SIDP_TON_50 16'h01F4
`define SIDP_TON_100 16'h03E8
`define SIDP_REF_NOM_MV 10'h1F4
`define SIDP_REF_40_MV 10'h0C8
`define SIDP_REF_50_MV 10'h0FA
`define SIDP_REF_70_MV 10'h15E
`define SIDP_REF_85_MV 10'h1A9
`endif

// File: rtl/sidp_stepper_input_decode.sv
// Purpose: input decode, serial configuration loading and chopping control
// Assumes: phase and control inputs asynchronous, comparator trip asynchronous
// Notes: oscillator modelled as a clk counter standing in for the external RC network
// Operation
// - all four phase lines low together selects programming mode
// - power outputs stay disabled throughout programming mode
// - entering all-low produces one internal clock shifting one bit in
// - all-low shorter than 0.2 us produces no programming clock
// - no further pulse until a phase line returns high then all low
// - bits enter at position zero, first bit reaches five after six pulses
// - serial data bit is current-reduce xor loop-select
// - full mode: each phase line drives its own low side, on when low
// - loop-select high gives open loop fixed on time, low closed loop
// - full mode reduced current when lines 1,2 or 3,4 high or reduce input
// - full mode disables output when lines 1,2 or 3,4 both low
// - simplified mode: line one phase A, two phase B, three enable
// - simplified closed loop reduced when line four low or reduce input high
// - simplified mode supports full-step drive only
// - bits zero and one pick reduced level 40, 50, 70 or 85 percent
// - nominal closed-loop threshold is a 0.5 V reference, reduced levels scale it
// - open loop chops at oscillator rate, bits two and three set on time
// - closed loop bit four picks full or exactly half oscillator rate
// - comparator trip resets chop flip-flop until next oscillator pulse sets it
// - during off time the paired winding low side is also switched on
// - reset clears the configuration register and disables power outputs
// - each phase change produces an extra synchronous oscillator pulse
`timescale 1ns/1ps
`include "sidp_regs.svh"
module sidp_stepper_input_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic phase_line_one,
    input wire logic phase_line_two,
    input wire logic phase_line_three,
    input wire logic phase_line_four,
    input wire logic current_reduce_input,
    input wire logic loop_select_input,
    input wire logic current_trip,
    output logic low_side_drive_one,
    output logic low_side_drive_two,
    output logic low_side_drive_three,
    output logic low_side_drive_four,
    output logic high_side_chop_switch,
    output logic [9:0] current_ref_mv,
    output logic [5:0] drive_configuration_shift,
    output logic programming_mode
);
    localparam int GUARD_CYC = `SIDP_GUARD_CYC;

    // three-stage synchronisers for the asynchronous inputs
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic [6:0] sync3_reg;
    logic [6:0] in_reg;
    wire [6:0] raw_in = {current_trip, loop_select_input, current_reduce_input,
        phase_line_four, phase_line_three, phase_line_two, phase_line_one};
    wire [6:0] agree = ~(sync2_reg ^ sync3_reg);
    wire [6:0] in_next = (agree & sync2_reg) | (~agree & in_reg);

    // phase lines reset to their idle high level so release does not look like all-low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= `SIDP_IN_RESET;
            sync2_reg <= `SIDP_IN_RESET;
            sync3_reg <= `SIDP_IN_RESET;
            in_reg <= `SIDP_IN_RESET;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            in_reg <= in_next;
        end
    end

    wire p1 = in_reg[0];
    wire p2 = in_reg[1];
    wire p3 = in_reg[2];
    wire p4 = in_reg[3];
    wire reduce_in = in_reg[4];
    wire loop_open = in_reg[5];
    wire trip = in_reg[6];

    // programming mode detect and guarded clock generation
    wire all_low = ~(p1 | p2 | p3 | p4);
    sidp_pkg::sidp_prog_e prog_reg;
    sidp_pkg::sidp_prog_e prog_next;
    logic [7:0] guard_reg;
    logic [7:0] guard_next;
    logic prog_clk;
    wire guard_met = (guard_reg >= 8'(GUARD_CYC - 1));

    always_comb begin
        prog_next = prog_reg;
        guard_next = 8'h00;
        prog_clk = 1'b0;
        case (prog_reg)
            sidp_pkg::SIDP_IDLE: begin
                if (all_low) begin
                    prog_next = sidp_pkg::SIDP_WAIT;
                end
            end
            sidp_pkg::SIDP_WAIT: begin
                if (!all_low) begin
                    prog_next = sidp_pkg::SIDP_IDLE;
                end else if (guard_met) begin
                    prog_clk = 1'b1;
                    prog_next = sidp_pkg::SIDP_DONE;
                end else begin
                    guard_next = guard_reg + 8'h01;
                end
            end
            sidp_pkg::SIDP_DONE: begin
                if (!all_low) begin
                    prog_next = sidp_pkg::SIDP_IDLE;
                end
            end
            default: begin
                prog_next = sidp_pkg::SIDP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_reg <= sidp_pkg::SIDP_IDLE;
            guard_reg <= 8'h00;
        end else begin
            prog_reg <= prog_next;
            guard_reg <= guard_next;
        end
    end

    // configuration shift register, loaded only on the programming clock
    logic [5:0] cfg_reg;
    wire serial_bit = reduce_in ^ loop_open;
    wire [5:0] cfg_next = prog_clk ? {cfg_reg[4:0], serial_bit} : cfg_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= `SIDP_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    wire cfg_bit_zero = cfg_reg[`SIDP_BIT_LVL0];
    wire cfg_bit_one = cfg_reg[`SIDP_BIT_LVL1];
    wire cfg_bit_two = cfg_reg[`SIDP_BIT_TON2];
    wire cfg_bit_three = cfg_reg[`SIDP_BIT_TON3];
    wire cfg_bit_four = cfg_reg[`SIDP_BIT_FREQ];
    wire cfg_bit_five = cfg_reg[`SIDP_BIT_FULL];

    // phase decode; simplified mode maps A/B onto complementary pairs (full step only)
    wire full_dis = (~p1 & ~p2) | (~p3 & ~p4);
    wire full_red = (p1 & p2) | (p3 & p4) | reduce_in;
    wire [3:0] full_on = {~p4, ~p3, ~p2, ~p1};
    wire [3:0] simp_on = {~p2, p2, ~p1, p1};
    wire simp_dis = ~p3;
    wire simp_red = ~p4 | reduce_in;
    wire [3:0] phase_on = cfg_bit_five ? full_on : simp_on;
    wire stage_dis = cfg_bit_five ? full_dis : simp_dis;
    wire reduced = cfg_bit_five ? full_red : (simp_red & ~loop_open);
    wire ton_dis = loop_open & cfg_bit_two & cfg_bit_three;
    wire out_dis = all_low | stage_dis | ton_dis;

    // reference level selection from the two level bits
    function automatic logic [9:0] ref_level(input logic b0, input logic b1);
        case ({b1, b0})
            2'b00: ref_level = `SIDP_REF_40_MV;
            2'b10: ref_level = `SIDP_REF_50_MV;
            2'b01: ref_level = `SIDP_REF_70_MV;
            default: ref_level = `SIDP_REF_85_MV;
        endcase
    endfunction
    wire [9:0] ref_mv = reduced ? ref_level(cfg_bit_zero, cfg_bit_one)
        : `SIDP_REF_NOM_MV;

    // oscillator with extra pulse on each phase change
    logic [3:0] phase_last_reg;
    logic [15:0] osc_reg;
    logic half_reg;
    wire phase_change = (phase_on != phase_last_reg) & ~all_low;
    wire osc_wrap = (osc_reg == `SIDP_OSC_PERIOD - 16'h0001);
    wire osc_pulse = osc_wrap | phase_change;
    wire [15:0] osc_next = osc_pulse ? 16'h0000 : osc_reg + 16'h0001;
    wire chop_set = loop_open ? osc_pulse
        : (osc_pulse & (~cfg_bit_four | half_reg));

    // open-loop on time from bits two and three
    function automatic logic [15:0] ton_len(input logic b2, input logic b3);
        case ({b3, b2})
            2'b00: ton_len = `SIDP_TON_75;
            2'b10: ton_len = `SIDP_TON_50;
            default: ton_len = `SIDP_TON_100;
        endcase
    endfunction
    wire ton_end = (osc_reg >= ton_len(cfg_bit_two, cfg_bit_three));

    // chop flip-flop: set by oscillator, reset by trip or on time end
    logic chop_reg;
    wire chop_clr = loop_open ? ton_end : trip;
    wire chop_next = chop_set ? 1'b1 : (chop_clr ? 1'b0 : chop_reg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_last_reg <= 4'h0;
            osc_reg <= 16'h0000;
            half_reg <= 1'b0;
            chop_reg <= 1'b0;
        end else begin
            phase_last_reg <= phase_on;
            osc_reg <= osc_next;
            half_reg <= osc_pulse ? ~half_reg : half_reg;
            chop_reg <= chop_next;
        end
    end

    // off time also turns on the paired low side to halve the current
    wire [3:0] pair_on = {phase_on[2], phase_on[3], phase_on[0], phase_on[1]};
    wire [3:0] ls_next = out_dis ? 4'h0
        : (chop_reg ? phase_on : (phase_on | pair_on));
    wire hs_next = ~out_dis & chop_reg;

    // registered drive outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_side_drive_one <= 1'b0;
            low_side_drive_two <= 1'b0;
            low_side_drive_three <= 1'b0;
            low_side_drive_four <= 1'b0;
            high_side_chop_switch <= 1'b0;
            current_ref_mv <= `SIDP_REF_NOM_MV;
            programming_mode <= 1'b0;
        end else begin
            low_side_drive_one <= ls_next[0];
            low_side_drive_two <= ls_next[1];
            low_side_drive_three <= ls_next[2];
            low_side_drive_four <= ls_next[3];
            high_side_chop_switch <= hs_next;
            current_ref_mv <= ref_mv;
            programming_mode <= all_low;
        end
    end

    assign drive_configuration_shift = cfg_reg;
endmodule
